/* src/timer_pair_defines.svh */
`ifndef TIMER_PAIR_DEFINES_SVH
`define TIMER_PAIR_DEFINES_SVH

// ****************************************
// Special function register addresses
// ****************************************
`define ADDR_CTRL 8'h88
`define ADDR_MODE 8'h89
`define ADDR_A_LO 8'h8a
`define ADDR_B_LO 8'h8b
`define ADDR_A_HI 8'h8c
`define ADDR_B_HI 8'h8d
`define ADDR_CLKSEL 8'h8e
`define ADDR_IRQEN 8'ha8

// ****************************************
// Field positions
// ****************************************
`define CTRL_FLAG_B 7
`define CTRL_RUN_B 6
`define CTRL_FLAG_A 5
`define CTRL_RUN_A 4
`define MODE_A_LSB 0
`define MODE_B_LSB 4
`define CLKSEL_PRE_LSB 0
`define CLKSEL_A 3
`define CLKSEL_B 4
`define IRQEN_A 1
`define IRQEN_B 3

// ****************************************
// Reset values and prescale counts
// ****************************************
`define RESET_BYTE 8'h00
`define DIV_SYS12 6'h0c
`define DIV_SYS4 6'h04
`define DIV_SYS48 6'h30
`define DIV_EXT8 6'h08

`endif

/* src/timer_pair_pkg.sv */
package timer_pair_pkg;

	typedef enum logic [1:0] {
		MODE_13BIT = 2'b00,
		MODE_16BIT = 2'b01,
		MODE_RELOAD8 = 2'b10,
		MODE_SPLIT = 2'b11
	} timer_mode_t;

	typedef enum logic [1:0] {
		PRE_SYS12 = 2'b00,
		PRE_SYS4 = 2'b01,
		PRE_SYS48 = 2'b10,
		PRE_EXT8 = 2'b11
	} prescale_t;

	// Same bit order as one nibble of the mode register
	typedef struct packed {
		logic gate;
		logic cnt_sel;
		timer_mode_t mode;
	} timer_cfg_t;

	typedef struct packed {
		logic ovf;
		logic [7:0] hi;
		logic [7:0] lo;
	} step_t;

endpackage : timer_pair_pkg

/* src/sync_edge.sv */
`timescale 1ns/10ps
`default_nettype none

module sync_edge (
	input wire logic clk,
	input wire logic rst,
	input wire logic pin,
	output logic level,
	output logic fall
);

	logic meta;
	logic last;

	// Only the second and third stages are looked at by the edge compare
	always_ff @(posedge clk) begin
		if (rst) begin
			meta <= 1'b1;
			level <= 1'b1;
			last <= 1'b1;
		end else begin
			meta <= pin;
			level <= meta;
			last <= level;
		end
	end

	assign fall = last & ~level;

endmodule : sync_edge

`default_nettype wire

/* src/prescale_tick.sv */
`timescale 1ns/10ps
`default_nettype none
`include "timer_pair_defines.svh"

module prescale_tick (
	input wire logic clk,
	input wire logic rst,
	input wire timer_pair_pkg::prescale_t sel,
	input wire logic ext_fall,
	output logic tick
);

	import timer_pair_pkg::*;

	logic [5:0] count;
	logic [5:0] limit;
	logic step;
	prescale_t sel_last;

	always_comb begin
		case (sel)
			PRE_SYS12: limit = `DIV_SYS12;
			PRE_SYS4: limit = `DIV_SYS4;
			PRE_SYS48: limit = `DIV_SYS48;
			default: limit = `DIV_EXT8;
		endcase
	end

	assign step = (sel == PRE_EXT8) ? ext_fall : 1'b1;

	// Restart on a change of divisor so no stretched first period
	always_ff @(posedge clk) begin
		if (rst || sel != sel_last) begin
			count <= 6'h00;
			tick <= 1'b0;
		end else if (step && count == limit - 6'h01) begin
			count <= 6'h00;
			tick <= 1'b1;
		end else begin
			count <= count + {5'h00, step};
			tick <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			sel_last <= PRE_SYS12;
		end else begin
			sel_last <= sel;
		end
	end

endmodule : prescale_tick

`default_nettype wire

/* src/legacy_dual_counter_timer.sv */
// Overview of operation
// - Each timer clocks from system clock or one of four shared prescaled clocks.
// - Counter function adds one per falling edge on the event pin.
// - Events up to a quarter of the system clock rate are counted.
// - Each count is 16 bits, reached as separate low and high bytes.
// - Four modes per timer, set independently by mode register bits.
// - Split mode exists only on timer A; timer B holds its count in mode 11.
// - 13-bit mode uses high byte plus low byte bits 4 to 0.
// - 13-bit wrap to zero sets the overflow flag and may interrupt.
// - Overflow interrupt forwarded only when that timer's enable bit is set.
// - Count select bit picks event pin (1) or internal clock (0).
// - Clock select bit picks system clock (1) or prescaled clock (0).
// - Outside split mode, count only while run is set and gate is off or gate input high.
// - Setting run keeps the count; software loads it before starting.
// - Timer B mirrors timer A with its own bytes, bits and gate.
// - Mode 00 13-bit, 01 16-bit, 10 reload, 11 split or inactive.
// - 16-bit mode uses all sixteen bits and overflows on full wrap.
// - Reload mode: low byte wrap sets flag, reloads low from high.
// - Software may clear a flag; interrupt vectoring clears it too.
`timescale 1ns/10ps
`default_nettype none
`include "timer_pair_defines.svh"

module legacy_dual_counter_timer (
	input wire logic REF_CLK,
	input wire logic SYS_RST,
	input wire logic [7:0] SFR_ADDR,
	input wire logic SFR_WR,
	input wire logic [7:0] SFR_WDATA,
	output logic [7:0] SFR_RDATA,
	input wire logic EVENT_PIN_A,
	input wire logic EVENT_PIN_B,
	input wire logic GATE_INPUT_A,
	input wire logic GATE_INPUT_B,
	input wire logic EXT_CLK_PIN,
	input wire logic IRQ_ACK_A,
	input wire logic IRQ_ACK_B,
	output logic IRQ_A,
	output logic IRQ_B
);

	import timer_pair_pkg::*;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	localparam int PIN_EV_A = 0;
	localparam int PIN_EV_B = 1;
	localparam int PIN_GATE_A = 2;
	localparam int PIN_GATE_B = 3;
	localparam int PIN_EXT = 4;

	logic [4:0] pin_raw, pin_lvl, pin_fall;

	assign pin_raw = {EXT_CLK_PIN, GATE_INPUT_B, GATE_INPUT_A, EVENT_PIN_B, EVENT_PIN_A};

	// Two-flop sync plus one compare stage: 2-cycle levels always seen
	generate
		for (genvar i = 0; i < 5; i++) begin : g_pin
			sync_edge u_sync (
				.clk(REF_CLK),
				.rst(SYS_RST),
				.pin(pin_raw[i]),
				.level(pin_lvl[i]),
				.fall(pin_fall[i])
			);
		end
	endgenerate

	// ****************************************
	// Register file
	// ****************************************
	logic run_a, run_b, flag_a, flag_b;
	timer_cfg_t cfg_a, cfg_b;
	prescale_t prescale_field;
	logic clk_sel_a, clk_sel_b, irq_en_a, irq_en_b;
	logic [7:0] lo_a, hi_a, lo_b, hi_b;
	logic wr_ctrl, wr_mode, wr_clk, wr_irq;
	logic wr_a_lo, wr_a_hi, wr_b_lo, wr_b_hi;

	assign wr_ctrl = SFR_WR && SFR_ADDR == `ADDR_CTRL;
	assign wr_mode = SFR_WR && SFR_ADDR == `ADDR_MODE;
	assign wr_clk = SFR_WR && SFR_ADDR == `ADDR_CLKSEL;
	assign wr_irq = SFR_WR && SFR_ADDR == `ADDR_IRQEN;
	assign wr_a_lo = SFR_WR && SFR_ADDR == `ADDR_A_LO;
	assign wr_a_hi = SFR_WR && SFR_ADDR == `ADDR_A_HI;
	assign wr_b_lo = SFR_WR && SFR_ADDR == `ADDR_B_LO;
	assign wr_b_hi = SFR_WR && SFR_ADDR == `ADDR_B_HI;

	// Run bits never touch the count registers
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			run_a <= 1'b0;
			run_b <= 1'b0;
		end else if (wr_ctrl) begin
			run_a <= SFR_WDATA[`CTRL_RUN_A];
			run_b <= SFR_WDATA[`CTRL_RUN_B];
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			cfg_a <= timer_cfg_t'(4'h0);
			cfg_b <= timer_cfg_t'(4'h0);
		end else if (wr_mode) begin
			cfg_a <= timer_cfg_t'(SFR_WDATA[`MODE_A_LSB +: 4]);
			cfg_b <= timer_cfg_t'(SFR_WDATA[`MODE_B_LSB +: 4]);
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			prescale_field <= PRE_SYS12;
			clk_sel_a <= 1'b0;
			clk_sel_b <= 1'b0;
		end else if (wr_clk) begin
			prescale_field <= prescale_t'(SFR_WDATA[`CLKSEL_PRE_LSB +: 2]);
			clk_sel_a <= SFR_WDATA[`CLKSEL_A];
			clk_sel_b <= SFR_WDATA[`CLKSEL_B];
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			irq_en_a <= 1'b0;
			irq_en_b <= 1'b0;
		end else if (wr_irq) begin
			irq_en_a <= SFR_WDATA[`IRQEN_A];
			irq_en_b <= SFR_WDATA[`IRQEN_B];
		end
	end

	// ****************************************
	// Clock sources
	// ****************************************
	logic pre_tick;

	prescale_tick u_pre (
		.clk(REF_CLK),
		.rst(SYS_RST),
		.sel(prescale_field),
		.ext_fall(pin_fall[PIN_EXT]),
		.tick(pre_tick)
	);

	logic split, tick_a, tick_b, time_a, time_b;
	logic en_a, en_b, inc_a, inc_b, inc_ah;

	assign split = cfg_a.mode == MODE_SPLIT;
	assign time_a = clk_sel_a | pre_tick;
	assign time_b = clk_sel_b | pre_tick;
	assign tick_a = cfg_a.cnt_sel ? pin_fall[PIN_EV_A] : time_a;
	assign tick_b = cfg_b.cnt_sel ? pin_fall[PIN_EV_B] : time_b;
	assign en_a = run_a & (~cfg_a.gate | pin_lvl[PIN_GATE_A]);
	assign en_b = run_b & (~cfg_b.gate | pin_lvl[PIN_GATE_B]);
	assign inc_a = en_a & tick_a;
	// Upper half of a split timer A borrows timer B's run bit
	assign inc_ah = split & run_b & time_a;
	// With A split, B runs from its mode alone, internal clock only
	always_comb begin
		if (cfg_b.mode == MODE_SPLIT) begin
			inc_b = 1'b0;
		end else if (split) begin
			inc_b = time_b;
		end else begin
			inc_b = en_b & tick_b;
		end
	end

	// ****************************************
	// Count step
	// ****************************************
	function automatic step_t count_step(timer_mode_t mode, logic [7:0] hi, logic [7:0] lo);
		step_t s;
		logic [13:0] w13;
		logic [16:0] w16;
		s = '0;
		w13 = {1'b0, hi, lo[4:0]} + 14'h0001;
		w16 = {1'b0, hi, lo} + 17'h00001;
		case (mode)
			MODE_13BIT: begin
				s.hi = w13[12:5];
				s.lo = {lo[7:5], w13[4:0]};
				s.ovf = w13[13];
			end
			MODE_16BIT: begin
				s.hi = w16[15:8];
				s.lo = w16[7:0];
				s.ovf = w16[16];
			end
			MODE_RELOAD8: begin
				s.hi = hi;
				s.lo = (lo == 8'hff) ? hi : lo + 8'h01;
				s.ovf = lo == 8'hff;
			end
			default: begin
				s.hi = hi;
				s.lo = lo + 8'h01;
				s.ovf = lo == 8'hff;
			end
		endcase
		return s;
	endfunction : count_step

	step_t nxt_a, nxt_b;
	logic set_a, set_b, ovf_ah;

	assign nxt_a = count_step(cfg_a.mode, hi_a, lo_a);
	assign nxt_b = count_step(cfg_b.mode, hi_b, lo_b);
	assign ovf_ah = inc_ah & (hi_a == 8'hff);
	assign set_a = inc_a & nxt_a.ovf;
	// B's own overflow cannot flag while A is split
	assign set_b = split ? ovf_ah : (inc_b & nxt_b.ovf);

	// Software load wins over a count step in the same cycle
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			lo_a <= `RESET_BYTE;
		end else if (wr_a_lo) begin
			lo_a <= SFR_WDATA;
		end else if (inc_a) begin
			lo_a <= nxt_a.lo;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			hi_a <= `RESET_BYTE;
		end else if (wr_a_hi) begin
			hi_a <= SFR_WDATA;
		end else if (split) begin
			if (inc_ah) begin
				hi_a <= hi_a + 8'h01;
			end
		end else if (inc_a) begin
			hi_a <= nxt_a.hi;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			lo_b <= `RESET_BYTE;
		end else if (wr_b_lo) begin
			lo_b <= SFR_WDATA;
		end else if (inc_b) begin
			lo_b <= nxt_b.lo;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			hi_b <= `RESET_BYTE;
		end else if (wr_b_hi) begin
			hi_b <= SFR_WDATA;
		end else if (inc_b) begin
			hi_b <= nxt_b.hi;
		end
	end

	// ****************************************
	// Overflow flags and interrupt requests
	// ****************************************
	logic held_a, held_b;

	assign held_a = wr_ctrl ? SFR_WDATA[`CTRL_FLAG_A] : flag_a;
	assign held_b = wr_ctrl ? SFR_WDATA[`CTRL_FLAG_B] : flag_b;

	// A new overflow beats a clear arriving in the same cycle
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			flag_a <= 1'b0;
			flag_b <= 1'b0;
		end else begin
			flag_a <= set_a | (held_a & ~IRQ_ACK_A);
			flag_b <= set_b | (held_b & ~IRQ_ACK_B);
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			IRQ_A <= 1'b0;
			IRQ_B <= 1'b0;
		end else begin
			IRQ_A <= flag_a & irq_en_a;
			IRQ_B <= flag_b & irq_en_b;
		end
	end

	// ****************************************
	// Read path
	// ****************************************
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			SFR_RDATA <= `RESET_BYTE;
		end else begin
			case (SFR_ADDR)
				`ADDR_CTRL: SFR_RDATA <= {flag_b, run_b, flag_a, run_a, 4'h0};
				`ADDR_MODE: SFR_RDATA <= {cfg_b, cfg_a};
				`ADDR_CLKSEL: SFR_RDATA <= {3'h0, clk_sel_b, clk_sel_a, 1'b0, prescale_field};
				`ADDR_IRQEN: SFR_RDATA <= {4'h0, irq_en_b, 1'b0, irq_en_a, 1'b0};
				`ADDR_A_LO: SFR_RDATA <= lo_a;
				`ADDR_A_HI: SFR_RDATA <= hi_a;
				`ADDR_B_LO: SFR_RDATA <= lo_b;
				`ADDR_B_HI: SFR_RDATA <= hi_b;
				default: SFR_RDATA <= 8'h00;
			endcase
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (SYS_RST);
	logic no_wr_a;
	assign no_wr_a = !wr_a_lo && !wr_a_hi;
	AST_EVENT_ONCE: assert property (
		pin_fall[PIN_EV_A] |=> !pin_fall[PIN_EV_A]) else $error("event edge seen twice");
	AST_EVENT_STEP: assert property (
		cfg_a.cnt_sel && en_a && pin_fall[PIN_EV_A] && cfg_a.mode == MODE_16BIT && no_wr_a
		|=> {hi_a, lo_a} == $past({hi_a, lo_a}) + 16'h0001
	) else $error("event did not step the count");
	AST_GATE_HOLD: assert property (
		(cfg_a.gate && !pin_lvl[PIN_GATE_A]) || !run_a |-> !inc_a
	) else $error("timer counted while gated off");
	AST_SYSCLK_RUN: assert property (
		run_a && !cfg_a.gate && !cfg_a.cnt_sel && clk_sel_a |-> inc_a
	) else $error("system clock source did not count");
	// A software write or vectoring right after the wrap may legally clear the flag
	AST_WRAP13: assert property (
		cfg_a.mode == MODE_13BIT && inc_a && hi_a == 8'hff && lo_a[4:0] == 5'h1f && no_wr_a
		|=> flag_a && hi_a == 8'h00 && lo_a[4:0] == 5'h00 ##1 (flag_a || $past(wr_ctrl || IRQ_ACK_A))
	) else $error("13-bit wrap wrong");
	AST_RELOAD: assert property (
		cfg_a.mode == MODE_RELOAD8 && inc_a && lo_a == 8'hff && no_wr_a
		|=> flag_a && lo_a == $past(hi_a) && hi_a == $past(hi_a)
	) else $error("reload wrong");
	AST_FLAG_STAYS: assert property (
		flag_a && !IRQ_ACK_A && !wr_ctrl |=> flag_a) else $error("flag dropped by itself");
	AST_ACK_CLEAR: assert property (
		IRQ_ACK_A && !set_a && !wr_ctrl |=> !flag_a) else $error("vectoring did not clear flag");
	AST_IRQ_ENABLE: assert property (
		IRQ_B |-> $past(irq_en_b) && $past(flag_b)) else $error("interrupt without enable");
	// In split mode the high byte belongs to the run bit of timer B
	AST_RUN_KEEPS: assert property (
		wr_ctrl && SFR_WDATA[`CTRL_RUN_A] && !run_a && no_wr_a
		|=> lo_a == $past(lo_a) && (hi_a == $past(hi_a) || $past(inc_ah))
	) else $error("setting run changed count");
	AST_B_INACTIVE: assert property (
		cfg_b.mode == MODE_SPLIT && !wr_b_lo && !wr_b_hi
		|=> lo_b == $past(lo_b) && hi_b == $past(hi_b)
	) else $error("timer B counted in mode 3");
	AST_SPLIT_HIGH: assert property (
		split && inc_ah && hi_a == 8'hff && !wr_a_hi |=> flag_b && hi_a == 8'h00
	) else $error("split upper byte overflow wrong");

	COV_WRAP13: cover property (cfg_a.mode == MODE_13BIT && set_a);
	COV_RELOAD: cover property (cfg_b.mode == MODE_RELOAD8 && set_b);
	COV_SPLIT: cover property (split && ovf_ah);
	COV_EVENT: cover property (cfg_a.cnt_sel && inc_a ##[1:8] inc_a);

endmodule : legacy_dual_counter_timer

`default_nettype wire

/* test/event_source.sv */
`timescale 1ns/10ps
`default_nettype none

module event_source (
	input wire logic clk,
	output logic event_a,
	output logic event_b,
	output logic gate_a,
	output logic gate_b,
	output logic ext_clk
);
	logic [1:0] ph;

	initial begin
		event_a = 1'b1;
		event_b = 1'b1;
		gate_a = 1'b1;
		gate_b = 1'b1;
		ext_clk = 1'b1;
		ph = 2'h0;
	end

	// ****************************************
	// Free oscillator, one fall every four system clocks
	// ****************************************
	always @(negedge clk) begin
		ph <= ph + 2'h1;
		ext_clk <= ~ph[1];
	end

	// ****************************************
	// Event bursts; each level stands hold clocks, hold 2 is quarter rate
	// ****************************************
	task automatic pulse(input bit sel_b, input int n, input int hold);
		int i;
		for (i = 0; i < n; i++) begin
			@(negedge clk);
			if (sel_b) event_b = 1'b0; else event_a = 1'b0;
			repeat (hold) @(negedge clk);
			if (sel_b) event_b = 1'b1; else event_a = 1'b1;
			repeat (hold - 1) @(negedge clk);
		end
	endtask : pulse

	task automatic set_gate(input logic a, input logic b);
		@(negedge clk);
		gate_a = a;
		gate_b = b;
		repeat (4) @(negedge clk);
	endtask : set_gate
endmodule : event_source

`default_nettype wire

/* test/tb_legacy_dual_counter_timer.sv */
`timescale 1ns/10ps
`default_nettype none
`include "timer_pair_defines.svh"

`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin err_count++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end

module tb_legacy_dual_counter_timer;
	logic ref_clk, sys_rst, sfr_wr, irq_a, irq_b, ack_a, ack_b;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, v;
	logic ev_a, ev_b, g_a, g_b, ext;
	logic [15:0] c;
	int err_count, samples_checked, i;
	logic [7:0] addrs [8] = '{`ADDR_CTRL, `ADDR_MODE, `ADDR_A_LO, `ADDR_B_LO, `ADDR_A_HI,
		`ADDR_B_HI, `ADDR_CLKSEL, `ADDR_IRQEN};
	logic [7:0] csel [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h08};
	int div [5] = '{12, 4, 48, 32, 1};

	legacy_dual_counter_timer u_legacy_dual_counter_timer (.REF_CLK(ref_clk), .SYS_RST(sys_rst),
		.SFR_ADDR(sfr_addr), .SFR_WR(sfr_wr), .SFR_WDATA(sfr_wdata), .SFR_RDATA(sfr_rdata),
		.EVENT_PIN_A(ev_a), .EVENT_PIN_B(ev_b), .GATE_INPUT_A(g_a), .GATE_INPUT_B(g_b),
		.EXT_CLK_PIN(ext), .IRQ_ACK_A(ack_a), .IRQ_ACK_B(ack_b), .IRQ_A(irq_a), .IRQ_B(irq_b));

	event_source u_event_source (.clk(ref_clk), .event_a(ev_a), .event_b(ev_b), .gate_a(g_a),
		.gate_b(g_b), .ext_clk(ext));

	always #20 ref_clk = ~ref_clk;

	// ****************************************
	// Register bus
	// ****************************************
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge ref_clk);
		sfr_wr = 1'b0;
	endtask : wr

	// Read data is registered, so it is taken one clock after the address
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge ref_clk);
		sfr_addr = a;
		@(negedge ref_clk);
		d = sfr_rdata;
	endtask : rd

	task automatic rd16(input bit b, output logic [15:0] d);
		rd(b ? `ADDR_B_LO : `ADDR_A_LO, d[7:0]);
		rd(b ? `ADDR_B_HI : `ADDR_A_HI, d[15:8]);
	endtask : rd16

	task automatic wait_ctrl(input int b);
		int k;
		v = 8'h00;
		for (k = 0; k < 40 && v[b] !== 1'b1; k++) begin
			rd(`ADDR_CTRL, v);
		end
		`CHK("flag", 1'b1, v[b])
	endtask : wait_ctrl

	task automatic results;
		$display("Comparisons %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : results

	// The whole sequence needs about 2800 clocks
	initial begin
		repeat (20000) @(posedge ref_clk);
		err_count++;
		results();
	end

	initial begin
		ref_clk = 1'b0;
		sys_rst = 1'b1;
		sfr_wr = 1'b0;
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
		ack_a = 1'b0;
		ack_b = 1'b0;
		err_count = 0;
		samples_checked = 0;
		repeat (10) @(negedge ref_clk);
		sys_rst = 1'b0;
		// ****************************************
		// Reset values, unmapped address, byte access
		// ****************************************
		for (i = 0; i < 8; i++) begin
			rd(addrs[i], v);
			`CHK("reset", 8'h00, v)
		end
		rd(8'h55, v);
		`CHK("unmapped", 8'h00, v)
		wr(`ADDR_A_LO, 8'h5a);
		wr(`ADDR_B_HI, 8'hc3);
		rd16(0, c);
		`CHK("a_bytes", 16'h005a, c)
		rd16(1, c);
		`CHK("b_bytes", 16'hc300, c)
		// ****************************************
		// Event counting, gate and run
		// ****************************************
		wr(`ADDR_MODE, 8'h05);
		wr(`ADDR_A_LO, 8'h10);
		wr(`ADDR_A_HI, 8'h00);
		wr(`ADDR_CTRL, 8'h10);
		u_event_source.pulse(0, 5, 2);
		repeat (6) @(negedge ref_clk);
		rd16(0, c);
		`CHK("events", 16'h0015, c)
		wr(`ADDR_MODE, 8'h0d);
		u_event_source.set_gate(1'b0, 1'b1);
		u_event_source.pulse(0, 3, 2);
		repeat (6) @(negedge ref_clk);
		rd16(0, c);
		`CHK("gate_low", 16'h0015, c)
		u_event_source.set_gate(1'b1, 1'b1);
		u_event_source.pulse(0, 3, 3);
		repeat (6) @(negedge ref_clk);
		wr(`ADDR_CTRL, 8'h00);
		u_event_source.pulse(0, 2, 2);
		repeat (6) @(negedge ref_clk);
		rd16(0, c);
		`CHK("gate_high", 16'h0018, c)
		wr(`ADDR_MODE, 8'h50);
		wr(`ADDR_B_HI, 8'h00);
		wr(`ADDR_CTRL, 8'h40);
		u_event_source.pulse(1, 4, 2);
		repeat (6) @(negedge ref_clk);
		wr(`ADDR_CTRL, 8'h00);
		rd16(1, c);
		`CHK("b_events", 16'h0004, c)
		// ****************************************
		// 16-bit overflow, interrupt, flag hold and ack
		// ****************************************
		wr(`ADDR_CLKSEL, 8'h08);
		wr(`ADDR_MODE, 8'h01);
		wr(`ADDR_A_HI, 8'hff);
		wr(`ADDR_A_LO, 8'hfd);
		wr(`ADDR_IRQEN, 8'h02);
		wr(`ADDR_CTRL, 8'h10);
		for (i = 0; i < 30 && irq_a !== 1'b1; i++) @(negedge ref_clk);
		`CHK("irq_a", 1'b1, irq_a)
		wr(`ADDR_CTRL, 8'h20);
		rd(`ADDR_CTRL, v);
		`CHK("flag_hold", 8'h20, v)
		rd(`ADDR_A_HI, v);
		`CHK("wrap16", 8'h00, v)
		@(negedge ref_clk);
		ack_a = 1'b1;
		@(negedge ref_clk);
		ack_a = 1'b0;
		repeat (3) @(negedge ref_clk);
		`CHK("irq_ack", 1'b0, irq_a)
		rd(`ADDR_CTRL, v);
		`CHK("ack_clr", 8'h00, v)
		// ****************************************
		// 13-bit wrap with interrupt masked, then reload mode
		// ****************************************
		wr(`ADDR_IRQEN, 8'h00);
		wr(`ADDR_MODE, 8'h00);
		wr(`ADDR_A_HI, 8'hff);
		wr(`ADDR_A_LO, 8'h1d);
		wr(`ADDR_CTRL, 8'h10);
		wait_ctrl(`CTRL_FLAG_A);
		wr(`ADDR_CTRL, 8'h20);
		`CHK("masked", 1'b0, irq_a)
		rd(`ADDR_A_HI, v);
		`CHK("wrap13", 8'h00, v)
		wr(`ADDR_CTRL, 8'h00);
		rd(`ADDR_CTRL, v);
		`CHK("sw_clr", 8'h00, v)
		wr(`ADDR_MODE, 8'h02);
		wr(`ADDR_A_HI, 8'hf0);
		wr(`ADDR_A_LO, 8'hfe);
		wr(`ADDR_CTRL, 8'h10);
		wait_ctrl(`CTRL_FLAG_A);
		wr(`ADDR_CTRL, 8'h00);
		rd16(0, c);
		`CHK("reload", 12'hf0f, {c[15:8], c[7:4]})
		// ****************************************
		// Mode 3: timer B stops, timer A splits
		// ****************************************
		wr(`ADDR_CLKSEL, 8'h18);
		wr(`ADDR_MODE, 8'h30);
		wr(`ADDR_B_LO, 8'h00);
		wr(`ADDR_CTRL, 8'h40);
		repeat (20) @(negedge ref_clk);
		rd(`ADDR_B_LO, v);
		`CHK("b_stop", 8'h00, v)
		wr(`ADDR_MODE, 8'h03);
		wr(`ADDR_A_LO, 8'h00);
		wr(`ADDR_A_HI, 8'hfe);
		wr(`ADDR_IRQEN, 8'h08);
		for (i = 0; i < 30 && irq_b !== 1'b1; i++) @(negedge ref_clk);
		`CHK("split_b", 1'b1, irq_b)
		rd(`ADDR_A_LO, v);
		`CHK("split_lo", 8'h00, v)
		@(negedge ref_clk);
		ack_b = 1'b1;
		@(negedge ref_clk);
		ack_b = 1'b0;
		repeat (3) @(negedge ref_clk);
		`CHK("irq_ack_b", 1'b0, irq_b)
		wr(`ADDR_CTRL, 8'h00);
		// ****************************************
		// Five clock sources over 480 clocks, two ticks of divider phase allowed
		// ****************************************
		wr(`ADDR_MODE, 8'h01);
		for (i = 0; i < 5; i++) begin
			wr(`ADDR_A_LO, 8'h00);
			wr(`ADDR_A_HI, 8'h00);
			wr(`ADDR_CLKSEL, csel[i]);
			wr(`ADDR_CTRL, 8'h10);
			repeat (478) @(negedge ref_clk);
			wr(`ADDR_CTRL, 8'h00);
			rd16(0, c);
			`CHK("source", 1'b1, (int'(c) + 2 >= 480 / div[i]) && (int'(c) <= 480 / div[i] + 2))
		end
		results();
	end
endmodule : tb_legacy_dual_counter_timer

`default_nettype wire
